// *** dv/dic_volt_src.sv ***
`timescale 1ns/1ps
module dic_volt_src
	import dic_pkg::*;
(
	input wire logic ref_clk,                                // Clock
	input wire logic reset,                                  // Sync reset
	input wire logic set_en,                                 // Load one channel
	input wire logic [2:0] set_ch,                           // Channel to load
	input wire logic [DIC_V_W-1:0] set_val,                  // Level, 0.1 V units
	output logic [DIC_CHANNELS*DIC_V_W-1:0] voltage_in       // Measured levels
);
	// Measurement holds its last level, like a settled meter
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			voltage_in <= '0;
		end else if (set_en) begin
			voltage_in[set_ch*DIC_V_W +: DIC_V_W] <= set_val;
		end
	end
endmodule : dic_volt_src

// *** dv/digital_input_conditioner_tb.sv ***
`timescale 1ns/1ps
module digital_input_conditioner_tb
	import dic_pkg::*;
;
	localparam int MS = 10;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [11:0] paddr = '0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [DIC_CHANNELS*DIC_V_W-1:0] voltage_in;
	logic [DIC_CHANNELS-1:0] chan_out;
	logic set_en = 1'b0;
	logic [2:0] set_ch = '0;
	logic [DIC_V_W-1:0] set_val = '0;
	int err_total = 0;
	int checks_done = 0;

	always #5 ref_clk = ~ref_clk;

	dic_digital_input_conditioner #(.MS_CYCLES(MS)) dut (.ref_clk(ref_clk), .reset(reset),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .voltage_in(voltage_in),
		.module_base(8'h10), .input_channel_n(chan_out));
	dic_volt_src src (.ref_clk(ref_clk), .reset(reset), .set_en(set_en), .set_ch(set_ch),
		.set_val(set_val), .voltage_in(voltage_in));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [11:0] ra(input logic [2:0] ch, input logic [11:0] off);
		return off + 12'(ch) * DIC_CH_STRIDE;
	endfunction : ra

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// No assumed wait count; only the watchdog ends a stuck access
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic set_v(input logic [2:0] ch, input logic [DIC_V_W-1:0] v);
		@(posedge ref_clk);
		set_en <= 1'b1;
		set_ch <= ch;
		set_val <= v;
		@(posedge ref_clk);
		set_en <= 1'b0;
	endtask : set_v

	task automatic wms(input int n);
		repeat (n * MS) @(posedge ref_clk);
	endtask : wms

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t word got %h exp %h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_out(input logic [2:0] ch, input logic exp);
		checks_done++;
		if (chan_out[ch] !== exp) begin
			err_total++;
			$display("BAD %0t channel %0d got %b", $time, ch, chan_out[ch]);
		end
	endtask : chk_out

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_defaults;
		logic [31:0] r;
		logic e;
		apb(1'b0, ra(5, DIC_REG_ACT_THR), '0, r, e);
		chk_word(r, 32'h00000370);
		apb(1'b0, ra(5, DIC_REG_REL_THR), '0, r, e);
		chk_word(r, 32'h00000258);
		apb(1'b0, ra(5, DIC_REG_CTRL), '0, r, e);
		chk_word(r, 32'h00000000);
		apb(1'b0, ra(3, DIC_REG_STATUS), '0, r, e);
		chk_word(32'(r[15:8]), 32'h00000014);
		wr(ra(5, DIC_REG_ACT_THR), 32'h00000005);
		apb(1'b0, ra(5, DIC_REG_ACT_THR), '0, r, e);
		chk_word(r, 32'h000000A0);
		apb(1'b0, 12'h204, '0, r, e);
		chk_word({31'h0, e}, 32'h00000001);
	endtask : t_defaults

	task automatic t_open;
		logic [31:0] r;
		logic e;
		set_v(3'd0, 12'h3E8);
		wms(12);
		chk_out(3'd0, 1'b1);
		chk_word(32'(chan_out[7:1]), 32'h00000000);
		apb(1'b0, DIC_REG_STATE, '0, r, e);
		chk_word(r, 32'h00000001);
		apb(1'b0, ra(0, DIC_REG_COUNT), '0, r, e);
		chk_word(r, 32'h00000001);
		set_v(3'd0, 12'h2BC);
		wms(12);
		chk_out(3'd0, 1'b1);
		set_v(3'd0, 12'h1F4);
		wms(12);
		chk_out(3'd0, 1'b0);
		set_v(3'd0, 12'h3E8);
		wms(12);
		apb(1'b0, ra(0, DIC_REG_COUNT), '0, r, e);
		chk_word(r, 32'h00000002);
		wr(ra(0, DIC_REG_CLEAR), 32'h00000001);
		apb(1'b0, ra(0, DIC_REG_COUNT), '0, r, e);
		chk_word(r, 32'h00000000);
	endtask : t_open

	task automatic t_closed;
		wr(ra(1, DIC_REG_CTRL), 32'h00000001);
		wms(12);
		chk_out(3'd1, 1'b1);
		set_v(3'd1, 12'h3E8);
		wms(12);
		chk_out(3'd1, 1'b0);
	endtask : t_closed

	task automatic t_delays;
		wr(ra(2, DIC_REG_ACT_DLY), 32'h00000014);
		wr(ra(2, DIC_REG_DROP_DLY), 32'h00000014);
		set_v(3'd2, 12'h3E8);
		wms(14);
		chk_out(3'd2, 1'b0);
		set_v(3'd2, 12'h000);
		wms(8);
		set_v(3'd2, 12'h3E8);
		wms(14);
		chk_out(3'd2, 1'b0);
		wms(19);
		chk_out(3'd2, 1'b1);
		set_v(3'd2, 12'h000);
		wms(14);
		chk_out(3'd2, 1'b1);
		wms(19);
		chk_out(3'd2, 1'b0);
	endtask : t_delays

	task automatic t_ac;
		wr(ra(3, DIC_REG_CTRL), 32'h00000002);
		set_v(3'd3, 12'h3E8);
		wms(12);
		chk_out(3'd3, 1'b1);
		set_v(3'd3, 12'h1F4);
		wms(40);
		chk_out(3'd3, 1'b1);
		set_v(3'd3, 12'h032);
		wms(22);
		chk_out(3'd3, 1'b1);
		wms(21);
		chk_out(3'd3, 1'b0);
	endtask : t_ac

	// ------------------------------------------------------------
	// Sequence and verdict
	// ------------------------------------------------------------
	task automatic print_verdict;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : print_verdict

	initial begin
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		t_defaults();
		t_open();
		t_closed();
		t_delays();
		t_ac();
		print_verdict();
	end

	// Whole run is a few thousand cycles; 80k cycles means a hang
	initial begin
		#800_000;
		err_total++;
		print_verdict();
	end
endmodule : digital_input_conditioner_tb

// *** rtl/dic_digital_input_conditioner.sv ***
`timescale 1ns/1ps
module dic_digital_input_conditioner
	import dic_pkg::*;
#(
	parameter int MS_CYCLES = DIC_MS_CYCLES
) (
	input wire logic ref_clk,                                  // 100 MHz clock
	input wire logic reset,                                    // Sync reset, high
	input wire logic [11:0] paddr,                             // APB address
	input wire logic psel,                                     // APB select
	input wire logic penable,                                  // APB enable
	input wire logic pwrite,                                   // APB write
	input wire logic [31:0] pwdata,                            // APB write data
	output logic [31:0] prdata,                                // APB read data
	output logic pready,                                       // APB ready
	output logic pslverr,                                      // APB error
	input wire logic [DIC_CHANNELS*DIC_V_W-1:0] voltage_in,    // 0.1 V per lsb
	input wire logic [7:0] module_base,                        // Inputs ahead of us
	output logic [DIC_CHANNELS-1:0] input_channel_n            // Conditioned states
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	dic_state_s st;
	dic_state_s next_st;

	logic apb_access;
	logic apb_wr;
	logic addr_bad;
	logic [2:0] addr_ch;
	logic [11:0] addr_reg;
	logic [DIC_CHANNELS-1:0] clr_hit;
	logic [31:0] rd_val;

	assign apb_access = psel && penable && !st.pready;
	assign apb_wr = psel && penable && st.pready && pwrite;
	assign addr_ch = paddr[7:5];
	assign addr_reg = {7'b0, paddr[4:0]};
	assign addr_bad = (paddr[11:9] != 3'b0) || (paddr[1:0] != 2'b0) ||
		(paddr[8] && paddr[7:0] != DIC_REG_STATE[7:0]);

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign input_channel_n = st.out;

	function automatic logic [DIC_V_W-1:0] clamp_v(input logic [31:0] v,
			input logic [DIC_V_W-1:0] lo, input logic [DIC_V_W-1:0] hi);
		if (v < {20'b0, lo}) begin
			return lo;
		end else if (v > {20'b0, hi}) begin
			return hi;
		end
		return v[DIC_V_W-1:0];
	endfunction : clamp_v

	function automatic logic [DIC_DLY_W-1:0] clamp_d(input logic [31:0] v);
		if (v > {11'b0, DIC_DLY_MAX}) begin
			return DIC_DLY_MAX;
		end
		return v[DIC_DLY_W-1:0];
	endfunction : clamp_d

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	always_comb begin
		rd_val = 32'h0;
		if (paddr[8]) begin
			rd_val = {24'b0, st.out};
		end else begin
			case (addr_reg)
				DIC_REG_CTRL: begin
					rd_val[DIC_CTRL_NC_BIT] = st.nc[addr_ch];
					rd_val[DIC_CTRL_AC_BIT] = st.ac[addr_ch];
				end
				DIC_REG_ACT_THR: rd_val = {20'b0, st.act_thr[addr_ch]};
				DIC_REG_REL_THR: rd_val = {20'b0, st.rel_thr[addr_ch]};
				DIC_REG_ACT_DLY: rd_val = {11'b0, st.act_dly[addr_ch]};
				DIC_REG_DROP_DLY: rd_val = {11'b0, st.drop_dly[addr_ch]};
				DIC_REG_COUNT: rd_val = st.cnt[addr_ch];
				DIC_REG_STATUS: begin
					rd_val[DIC_ST_OUT_BIT] = st.out[addr_ch];
					rd_val[DIC_ST_RAW_BIT] = st.raw[addr_ch];
					rd_val[DIC_ST_NUM_LSB +: 8] = module_base + {5'b0, addr_ch} + 8'h01;
				end
				default: rd_val = 32'h0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [DIC_V_W-1:0] v;
		logic [DIC_V_W-1:0] rel_eff;
		logic [DIC_ELAPSED_W-1:0] need;
		logic e;
		logic raw_n;
		logic rise;
		v = '0;
		rel_eff = '0;
		need = '0;
		e = 1'b0;
		raw_n = 1'b0;
		rise = 1'b0;
		next_st = st;
		clr_hit = '0;

		// One ms tick, and a scan tick every fifth ms
		next_st.ms_tick = 1'b0;
		next_st.scan_tick = 1'b0;
		if (st.ms_cnt == 17'(MS_CYCLES - 1)) begin
			next_st.ms_cnt = '0;
			next_st.ms_tick = 1'b1;
			if (st.scan_cnt == 3'(DIC_SCAN_TIME_MS - 1)) begin
				next_st.scan_cnt = '0;
				next_st.scan_tick = 1'b1;
			end else begin
				next_st.scan_cnt = st.scan_cnt + 3'h1;
			end
		end else begin
			next_st.ms_cnt = st.ms_cnt + 17'h1;
		end

		// APB: one wait state, answer flopped
		next_st.pready = apb_access;
		next_st.pslverr = 1'b0;
		next_st.prdata = 32'h0;
		if (apb_access) begin
			next_st.pslverr = addr_bad;
			next_st.prdata = addr_bad ? 32'h0 : rd_val;
		end
		if (apb_wr && !addr_bad && !paddr[8] && addr_reg == DIC_REG_CLEAR) begin
			clr_hit[addr_ch] = pwdata[DIC_CLEAR_BIT];
		end

		for (int i = 0; i < DIC_CHANNELS; i++) begin
			v = voltage_in[i*DIC_V_W +: DIC_V_W];
			rel_eff = st.ac[i] ? (st.act_thr[i] / DIC_AC_REL_DIV) : st.rel_thr[i];
			// Hysteresis on the energised level; between thresholds it holds
			e = st.energ[i];
			if (st.scan_tick) begin
				if (v > st.act_thr[i]) begin
					e = 1'b1;
				end else if (v < rel_eff) begin
					e = 1'b0;
				end
			end
			next_st.energ[i] = e;
			raw_n = e ^ st.nc[i];
			next_st.raw[i] = raw_n;
			// Timer counts from the last raw change, so a reversal restarts it
			if (raw_n != st.raw[i]) begin
				next_st.elapsed[i] = '0;
			end else if (st.ms_tick && st.elapsed[i] != '1) begin
				next_st.elapsed[i] = st.elapsed[i] + 22'h1;
			end
			if (st.raw[i]) begin
				need = {1'b0, st.act_dly[i]};
			end else begin
				need = {1'b0, st.drop_dly[i]} + (st.ac[i] ? DIC_AC_EXTRA_MS : '0);
			end
			rise = 1'b0;
			if (st.scan_tick && st.raw[i] != st.out[i] && st.elapsed[i] >= need) begin
				next_st.out[i] = st.raw[i];
				rise = st.raw[i];
			end
			// Rise in the clearing cycle is kept
			if (clr_hit[i]) begin
				next_st.cnt[i] = {31'b0, rise};
			end else begin
				next_st.cnt[i] = st.cnt[i] + {31'b0, rise};
			end
		end

		if (apb_wr && !addr_bad && !paddr[8]) begin
			case (addr_reg)
				DIC_REG_CTRL: begin
					next_st.nc[addr_ch] = pwdata[DIC_CTRL_NC_BIT];
					next_st.ac[addr_ch] = pwdata[DIC_CTRL_AC_BIT];
				end
				DIC_REG_ACT_THR: begin
					next_st.act_thr[addr_ch] = clamp_v(pwdata, DIC_ACT_MIN, DIC_ACT_MAX);
				end
				DIC_REG_REL_THR: begin
					next_st.rel_thr[addr_ch] = clamp_v(pwdata, DIC_REL_MIN, DIC_REL_MAX);
				end
				DIC_REG_ACT_DLY: next_st.act_dly[addr_ch] = clamp_d(pwdata);
				DIC_REG_DROP_DLY: next_st.drop_dly[addr_ch] = clamp_d(pwdata);
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st <= '0;
			st.act_thr <= {DIC_CHANNELS{DIC_ACT_DEF}};
			st.rel_thr <= {DIC_CHANNELS{DIC_REL_DEF}};
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// Checks on channel 0, plus output moves on scan ticks for all channels, scan tick timing and APB ready
	// ------------------------------------------------------------
	logic [DIC_V_W-1:0] v0;
	logic [DIC_V_W-1:0] rel0;
	assign v0 = voltage_in[DIC_V_W-1:0];
	assign rel0 = st.ac[0] ? (st.act_thr[0] / DIC_AC_REL_DIV) : st.rel_thr[0];

	property p_out_on_scan;
		@(posedge ref_clk) disable iff (reset)
		(st.out != $past(st.out)) |-> $past(st.scan_tick);
	endproperty
	a_out_on_scan: assert property (p_out_on_scan) else $error("output moved off scan");

	property p_scan_period;
		@(posedge ref_clk) disable iff (reset)
		st.scan_tick |=> !st.scan_tick [*4];
	endproperty
	a_scan_period: assert property (p_scan_period) else $error("scan ticks too close");

	property p_above_act;
		@(posedge ref_clk) disable iff (reset)
		st.scan_tick && v0 > st.act_thr[0] |=> st.energ[0];
	endproperty
	a_above_act: assert property (p_above_act) else $error("no pickup above threshold");

	property p_below_rel;
		@(posedge ref_clk) disable iff (reset)
		st.scan_tick && v0 <= st.act_thr[0] && v0 < rel0 |=> !st.energ[0];
	endproperty
	a_below_rel: assert property (p_below_rel) else $error("no release below threshold");

	property p_ac_release;
		@(posedge ref_clk) disable iff (reset)
		st.scan_tick && st.ac[0] && v0 <= st.act_thr[0] &&
			v0 < st.act_thr[0] / DIC_AC_REL_DIV |=> !st.energ[0];
	endproperty
	a_ac_release: assert property (p_ac_release) else $error("ac release level wrong");

	property p_polarity;
		@(posedge ref_clk) disable iff (reset)
		##1 st.raw[0] == (st.energ[0] ^ $past(st.nc[0]));
	endproperty
	a_polarity: assert property (p_polarity) else $error("polarity not applied");

	property p_hold;
		@(posedge ref_clk) disable iff (reset)
		st.scan_tick && v0 <= st.act_thr[0] && v0 >= rel0 |=> $stable(st.energ[0]);
	endproperty
	a_hold: assert property (p_hold) else $error("state moved inside band");

	property p_act_delay;
		@(posedge ref_clk) disable iff (reset)
		$rose(st.out[0]) |-> $past(st.elapsed[0]) >= {1'b0, $past(st.act_dly[0])};
	endproperty
	a_act_delay: assert property (p_act_delay) else $error("rise before delay");

	property p_drop_delay;
		@(posedge ref_clk) disable iff (reset)
		$fell(st.out[0]) |-> $past(st.elapsed[0]) >= {1'b0, $past(st.drop_dly[0])} +
			($past(st.ac[0]) ? DIC_AC_EXTRA_MS : '0);
	endproperty
	a_drop_delay: assert property (p_drop_delay) else $error("fall before delay");

	property p_restart;
		@(posedge ref_clk) disable iff (reset)
		st.raw[0] != $past(st.raw[0]) |-> st.elapsed[0] == '0;
	endproperty
	a_restart: assert property (p_restart) else $error("delay not restarted");

	property p_count;
		@(posedge ref_clk) disable iff (reset)
		$rose(st.out[0]) && !$past(clr_hit[0]) |-> st.cnt[0] == $past(st.cnt[0]) + 32'h1;
	endproperty
	a_count: assert property (p_count) else $error("rise not counted");

	property p_clear;
		@(posedge ref_clk) disable iff (reset)
		$past(clr_hit[0]) && !$rose(st.out[0]) |-> st.cnt[0] == 32'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("counter not cleared");

	property p_apb_ready;
		@(posedge ref_clk) disable iff (reset)
		psel && penable && !pready |=> pready;
	endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("apb answer late");

endmodule : dic_digital_input_conditioner

// *** rtl/dic_pkg.sv ***
// Contract
// - Eight independent channels, own settings each
// - Logical number is preceding count plus position
// - Every channel re-evaluated once per 5 ms
// - Activation threshold 16.0..200.0 V, default 88
// - Above activation: NO active, NC inactive
// - Release threshold 10.0..200.0 V, default 60
// - Polarity, default NO, sets energised meaning
// - Rise held by activation delay, ms steps
// - Fall held by drop-off delay, ms steps
// - AC mode adds fixed 30 ms deactivation
// - AC mode forces release to 10% activation
// - 32-bit counter counts zero-to-one transitions
// - Clear command zeroes that channel's counter
package dic_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int DIC_CHANNELS = 8;
	localparam int DIC_V_W = 12;                  // Volts in 0.1 V units
	localparam int DIC_DLY_W = 21;                // Milliseconds
	localparam int DIC_ELAPSED_W = 22;
	localparam int DIC_CNT_W = 32;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int DIC_CLK_HZ = 100_000_000;
	localparam int DIC_MS_PER_S = 1000;
	localparam int DIC_MS_CYCLES = DIC_CLK_HZ / DIC_MS_PER_S;
	localparam int DIC_SCAN_TIME_MS = 5;
	localparam logic [DIC_ELAPSED_W-1:0] DIC_AC_EXTRA_MS = 22'h00001E;  // 30 ms

	// ------------------------------------------------------------
	// Setting limits and defaults
	// ------------------------------------------------------------
	localparam logic [DIC_V_W-1:0] DIC_ACT_MIN = 12'h0A0;   // 16.0 V
	localparam logic [DIC_V_W-1:0] DIC_ACT_MAX = 12'h7D0;   // 200.0 V
	localparam logic [DIC_V_W-1:0] DIC_ACT_DEF = 12'h370;   // 88.0 V
	localparam logic [DIC_V_W-1:0] DIC_REL_MIN = 12'h064;   // 10.0 V
	localparam logic [DIC_V_W-1:0] DIC_REL_MAX = 12'h7D0;   // 200.0 V
	localparam logic [DIC_V_W-1:0] DIC_REL_DEF = 12'h258;   // 60.0 V
	localparam logic [DIC_V_W-1:0] DIC_AC_REL_DIV = 12'h00A;
	localparam logic [DIC_DLY_W-1:0] DIC_DLY_MAX = 21'h1B7740;  // 1800.000 s

	// ------------------------------------------------------------
	// Register map: channel n at n * stride, globals above
	// ------------------------------------------------------------
	localparam logic [11:0] DIC_REG_CTRL = 12'h000;
	localparam logic [11:0] DIC_REG_ACT_THR = 12'h004;
	localparam logic [11:0] DIC_REG_REL_THR = 12'h008;
	localparam logic [11:0] DIC_REG_ACT_DLY = 12'h00C;
	localparam logic [11:0] DIC_REG_DROP_DLY = 12'h010;
	localparam logic [11:0] DIC_REG_COUNT = 12'h014;
	localparam logic [11:0] DIC_REG_CLEAR = 12'h018;
	localparam logic [11:0] DIC_REG_STATUS = 12'h01C;
	localparam logic [11:0] DIC_REG_STATE = 12'h100;
	localparam logic [11:0] DIC_CH_STRIDE = 12'h020;
	localparam int DIC_CTRL_NC_BIT = 0;
	localparam int DIC_CTRL_AC_BIT = 1;
	localparam int DIC_CLEAR_BIT = 0;
	localparam int DIC_ST_OUT_BIT = 0;
	localparam int DIC_ST_RAW_BIT = 1;
	localparam int DIC_ST_NUM_LSB = 8;

	typedef struct packed {
		logic [16:0] ms_cnt;
		logic [2:0] scan_cnt;
		logic ms_tick;
		logic scan_tick;
		logic [DIC_CHANNELS-1:0] nc;
		logic [DIC_CHANNELS-1:0] ac;
		logic [DIC_CHANNELS-1:0] energ;
		logic [DIC_CHANNELS-1:0] raw;
		logic [DIC_CHANNELS-1:0] out;
		logic [DIC_CHANNELS-1:0][DIC_V_W-1:0] act_thr;
		logic [DIC_CHANNELS-1:0][DIC_V_W-1:0] rel_thr;
		logic [DIC_CHANNELS-1:0][DIC_DLY_W-1:0] act_dly;
		logic [DIC_CHANNELS-1:0][DIC_DLY_W-1:0] drop_dly;
		logic [DIC_CHANNELS-1:0][DIC_ELAPSED_W-1:0] elapsed;
		logic [DIC_CHANNELS-1:0][DIC_CNT_W-1:0] cnt;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} dic_state_s;

endpackage : dic_pkg
